// file: core/iag_params.svh
/*
 Fixed codes and reset values of the indirect address generator.
 Assumes inclusion by iag_pkg and iag_core only.
*/
`ifndef IAG_PARAMS_SVH
`define IAG_PARAMS_SVH

`define IAG_ADDR_W      24
`define IAG_MODE_W      5
`define IAG_GRP_DISP    2'h0
`define IAG_GRP_IR0     2'h1
`define IAG_GRP_IR1     2'h2
`define IAG_GRP_SPEC    2'h3
`define IAG_MODE_PLAIN  5'h18
`define IAG_MODE_BITREV 5'h19
`define IAG_PTR_RST     24'h000000
`define IAG_SP_RST      24'h000000
`define IAG_STEP_ONE    24'h000001

`endif

// file: core/iag_pkg.sv
/*
 Types shared by the indirect address generator.
 Assumes iag_params.svh is on the include path.
*/
`include "iag_params.svh"

package iag_pkg;

    typedef logic [`IAG_ADDR_W-1:0] iag_addr_t;

    typedef enum logic [2:0] {
        IAG_OP_READ  = 3'b000,
        IAG_OP_WRITE = 3'b001,
        IAG_OP_NOP   = 3'b010,
        IAG_OP_DECBR = 3'b011,
        IAG_OP_PUSH  = 3'b100,
        IAG_OP_POP   = 3'b101
    } iag_op_e;

    typedef enum logic [2:0] {
        IAG_REG_IR0 = 3'b000,
        IAG_REG_IR1 = 3'b001,
        IAG_REG_BK  = 3'b010,
        IAG_REG_SP  = 3'b011,
        IAG_REG_AUX = 3'b100
    } iag_reg_e;

    typedef struct packed {
        iag_op_e                 op;
        logic [`IAG_MODE_W-1:0]  mode;
        logic [2:0]              ptrSel;
        logic [7:0]              disp;
        logic                    condTrue;
        logic                    targetIsReg;
        iag_addr_t               target;
        iag_addr_t               pc;
        logic [31:0]             srcData;
    } iag_req_s;

    typedef struct packed {
        iag_addr_t   addr;
        logic        memRead;
        logic        memWrite;
        logic [31:0] wData;
        logic        branch;
        iag_addr_t   pcNext;
        iag_addr_t   ptrNew;
    } iag_res_s;

endpackage

// file: core/iag_core.sv
/*
 Indirect address generator: eight pointers, two index registers, block size, stack pointer.
 Assumes one request per cycle from the operand fetch logic, all on ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "iag_params.svh"

module iag_core
    import iag_pkg::*;
#(
    parameter int ADDR_W = `IAG_ADDR_W,
    parameter int NUM_PTR = 8
) (
    // Clock and reset.
    input  wire logic      ref_clk,
    input  wire logic      rst_n,
    // Request from the decoder.
    input  wire logic      reqValid,
    input  wire iag_req_s  req,
    // Register load port.
    input  wire logic      regWrEn,
    input  wire iag_reg_e  regWrSel,
    input  wire logic [2:0] regWrPtr,
    input  wire iag_addr_t regWrData,
    // Result.
    output logic           resValid,
    output iag_res_s       res,
    output iag_addr_t      stackTopPointer
);

    generate
        if (ADDR_W != 24 || NUM_PTR != 8) begin : gBadParam
            $error("iag_core serves only 24-bit addresses and eight pointers.");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        iag_addr_t ea;
        logic      upd;
        iag_addr_t newPtr;
    } iag_ea_s;

    // The buffer occupies the aligned window of the smallest power of two above the block size.
    function automatic iag_addr_t circStep(iag_addr_t ptr, iag_addr_t step, logic sub, iag_addr_t bk);
        iag_addr_t mask;
        logic [ADDR_W:0] off;
        mask = '0;
        off = '0;
        for (int i = 0; i < ADDR_W; i++) begin
            if (bk[i]) begin
                mask = iag_addr_t'((25'h1 << (i + 1)) - 25'h1);
            end
        end
        if (bk == '0) begin
            return sub ? ptr - step : ptr + step;
        end
        off = sub ? {1'b0, ptr & mask} - {1'b0, step} : {1'b0, ptr & mask} + {1'b0, step};
        if (sub && off[ADDR_W]) begin
            off = off + {1'b0, bk};
        end else if (!sub && off >= {1'b0, bk}) begin
            off = off - {1'b0, bk};
        end
        return (ptr & ~mask) | off[ADDR_W-1:0];
    endfunction

    function automatic iag_addr_t bitRev(iag_addr_t v);
        iag_addr_t r;
        r = '0;
        for (int i = 0; i < ADDR_W; i++) begin
            r[i] = v[ADDR_W-1-i];
        end
        return r;
    endfunction

    function automatic iag_ea_s calcEa(logic [4:0] mode, iag_addr_t ptr, iag_addr_t disp,
                                       iag_addr_t ir0, iag_addr_t ir1, iag_addr_t bk);
        iag_ea_s   e;
        iag_addr_t step;
        iag_addr_t sum;
        e = '{ea: ptr, upd: 1'b0, newPtr: ptr};
        case (mode[4:3])
            `IAG_GRP_DISP: step = disp;
            `IAG_GRP_IR0:  step = ir0;
            `IAG_GRP_IR1:  step = ir1;
            default:       step = ir0;
        endcase
        sum = mode[0] ? ptr - step : ptr + step;
        if (mode[4:3] == `IAG_GRP_SPEC) begin
            if (mode == `IAG_MODE_BITREV) begin
                e.upd = 1'b1;
                e.newPtr = bitRev(bitRev(ptr) + bitRev(ir0));
            end
        end else if (!mode[2]) begin
            e.ea = sum;
            e.upd = mode[1];
            e.newPtr = sum;
        end else begin
            e.upd = 1'b1;
            e.newPtr = mode[1] ? circStep(ptr, step, mode[0], bk) : sum;
        end
        return e;
    endfunction

    ////////////////////////////////////////////////////////////////////////////

    iag_addr_t auxPointerReg [NUM_PTR];
    iag_addr_t auxPointerNext [NUM_PTR];
    iag_addr_t indexRegZero_reg, indexRegZero_next;
    iag_addr_t indexRegOne_reg, indexRegOne_next;
    iag_addr_t blockSize_reg, blockSize_next;
    iag_addr_t stackTop_reg, stackTop_next;
    logic      resValid_reg, resValid_next;
    iag_res_s  res_reg, res_next;
    iag_addr_t ptrCur;
    iag_ea_s   eaCalc;
    iag_addr_t decPtr;
    iag_addr_t bufMask;

    assign ptrCur = auxPointerReg[req.ptrSel];
    assign eaCalc = calcEa(req.mode, ptrCur, {16'h0000, req.disp}, indexRegZero_reg, indexRegOne_reg,
                           blockSize_reg);
    assign decPtr = ptrCur - `IAG_STEP_ONE;

    // Smearing the block size rightwards gives the window mask apart from circStep, for the range check.
    always_comb begin
        bufMask = blockSize_reg;
        for (int sh = 1; sh < ADDR_W; sh = sh * 2) begin
            bufMask = bufMask | (bufMask >> sh);
        end
    end

    always_comb begin
        auxPointerNext = auxPointerReg;
        indexRegZero_next = indexRegZero_reg;
        indexRegOne_next = indexRegOne_reg;
        blockSize_next = blockSize_reg;
        stackTop_next = stackTop_reg;
        resValid_next = reqValid;
        res_next = '0;
        // A load from the decoder yields to an update by the request in the same cycle.
        if (regWrEn) begin
            case (regWrSel)
                IAG_REG_IR0: indexRegZero_next = regWrData;
                IAG_REG_IR1: indexRegOne_next = regWrData;
                IAG_REG_BK:  blockSize_next = regWrData;
                IAG_REG_SP:  stackTop_next = regWrData;
                IAG_REG_AUX: auxPointerNext[regWrPtr] = regWrData;
                default:     ;
            endcase
        end
        if (reqValid) begin
            res_next.ptrNew = ptrCur;
            res_next.pcNext = req.pc + `IAG_STEP_ONE;
            case (req.op)
                IAG_OP_READ, IAG_OP_WRITE, IAG_OP_NOP: begin
                    res_next.addr = eaCalc.ea;
                    res_next.memRead = (req.op == IAG_OP_READ);
                    res_next.memWrite = (req.op == IAG_OP_WRITE);
                    res_next.wData = req.srcData;
                    if (eaCalc.upd) begin
                        auxPointerNext[req.ptrSel] = eaCalc.newPtr;
                        res_next.ptrNew = eaCalc.newPtr;
                    end
                end
                IAG_OP_DECBR: begin
                    auxPointerNext[req.ptrSel] = decPtr;
                    res_next.ptrNew = decPtr;
                    if (req.condTrue && !decPtr[ADDR_W-1]) begin
                        res_next.branch = 1'b1;
                        res_next.pcNext = req.targetIsReg ? req.target
                                                          : req.target + req.pc + `IAG_STEP_ONE;
                    end
                end
                IAG_OP_PUSH: begin
                    stackTop_next = stackTop_reg + `IAG_STEP_ONE;
                    res_next.addr = stackTop_reg + `IAG_STEP_ONE;
                    res_next.memWrite = 1'b1;
                    res_next.wData = req.srcData;
                end
                IAG_OP_POP: begin
                    res_next.addr = stackTop_reg;
                    res_next.memRead = 1'b1;
                    stackTop_next = stackTop_reg - `IAG_STEP_ONE;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_PTR; i++) begin
                auxPointerReg[i] <= `IAG_PTR_RST;
            end
            indexRegZero_reg <= `IAG_PTR_RST;
            indexRegOne_reg <= `IAG_PTR_RST;
            blockSize_reg <= `IAG_PTR_RST;
            stackTop_reg <= `IAG_SP_RST;
            resValid_reg <= 1'b0;
            res_reg <= '0;
        end else begin
            auxPointerReg <= auxPointerNext;
            indexRegZero_reg <= indexRegZero_next;
            indexRegOne_reg <= indexRegOne_next;
            blockSize_reg <= blockSize_next;
            stackTop_reg <= stackTop_next;
            resValid_reg <= resValid_next;
            res_reg <= res_next;
        end
    end

    assign resValid = resValid_reg;
    assign res = res_reg;
    assign stackTopPointer = stackTop_reg;

    ////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    AST_PRE_DISP: assert property (
        reqValid && !req.op[2] && req.op != IAG_OP_DECBR && req.mode == 5'h00 && !regWrEn |=>
        res.addr == $past(ptrCur) + {16'h0000, $past(req.disp)}
        && auxPointerReg[$past(req.ptrSel)] == $past(ptrCur)
    ) else $error("Predisplacement address or pointer wrong.");

    AST_POST_DISP: assert property (
        reqValid && req.op != IAG_OP_DECBR && !req.op[2] && req.mode == 5'h05 && !regWrEn |=>
        res.addr == $past(ptrCur) && auxPointerReg[$past(req.ptrSel)] == $past(ptrCur) - $past(req.disp)
    ) else $error("Post-subtract displacement wrong.");

    AST_PRE_IR0: assert property (
        reqValid && req.op == IAG_OP_WRITE && req.mode == 5'h0A |=>
        res.addr == $past(ptrCur) + $past(indexRegZero_reg) && res.ptrNew == res.addr && res.memWrite
    ) else $error("Preindex zero modify wrong.");

    AST_PRE_IR1: assert property (
        reqValid && req.op == IAG_OP_READ && req.mode == 5'h11 |=>
        res.addr == $past(ptrCur) - $past(indexRegOne_reg) && res.ptrNew == $past(ptrCur)
    ) else $error("Preindex one subtract wrong.");

    AST_CIRC_RANGE: assert property (
        reqValid && !req.op[2] && req.op != IAG_OP_DECBR && req.mode[4:1] == 4'h7 && blockSize_reg != '0
        && indexRegZero_reg < blockSize_reg && (ptrCur & bufMask) < blockSize_reg |=>
        ((res.ptrNew ^ $past(ptrCur)) & ~$past(bufMask)) == '0
        && (res.ptrNew & $past(bufMask)) < $past(blockSize_reg)
        && res.addr == $past(ptrCur)
    ) else $error("Circular step left the buffer.");

    AST_DECBR: assert property (
        reqValid && req.op == IAG_OP_DECBR |=>
        res.ptrNew == $past(ptrCur) - 24'h000001
        && res.branch == ($past(req.condTrue) && !res.ptrNew[23])
        && (res.branch || res.pcNext == $past(req.pc) + 24'h000001)
    ) else $error("Decrement-and-branch wrong.");

    AST_PUSH: assert property (
        reqValid && req.op == IAG_OP_PUSH && !regWrEn |=>
        stackTopPointer == $past(stackTopPointer) + 24'h000001 && res.addr == stackTopPointer
        && res.memWrite && res.wData == $past(req.srcData)
    ) else $error("Push order wrong.");

    AST_POP: assert property (
        reqValid && req.op == IAG_OP_POP && !regWrEn |=>
        res.addr == $past(stackTopPointer) && res.memRead
        && stackTopPointer == $past(stackTopPointer) - 24'h000001
    ) else $error("Pop address or pointer wrong.");

    AST_NOP: assert property (
        reqValid && req.op == IAG_OP_NOP && req.mode == 5'h04 |=>
        !res.memRead && !res.memWrite && res.ptrNew == $past(ptrCur) + {16'h0000, $past(req.disp)}
    ) else $error("No-operation must update pointer only.");

    AST_POST_IR1: assert property (
        reqValid && !req.op[2] && req.op != IAG_OP_DECBR && req.mode == 5'h14 && !regWrEn |=>
        res.addr == $past(ptrCur) && res.ptrNew == $past(ptrCur) + $past(indexRegOne_reg)
        && auxPointerReg[$past(req.ptrSel)] == res.ptrNew
    ) else $error("Postindex one add wrong.");

    AST_PLAIN: assert property (
        reqValid && !req.op[2] && req.op != IAG_OP_DECBR && req.mode == 5'h18 |=>
        res.addr == $past(ptrCur) && res.ptrNew == $past(ptrCur)
    ) else $error("Plain indirect must not move the pointer.");

    AST_VALID: assert property (
        resValid == $past(reqValid)
    ) else $error("Result strobe misaligned.");

endmodule
`default_nettype wire

// file: tb/iag_decoder_model.sv
/*
 Model of the decoder and operand fetch logic that feeds the address generator.
 Assumes the bench calls its tasks from one process, all on ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none

module iag_decoder_model
    import iag_pkg::*;
(
    // Clock.
    input  wire logic      ref_clk,
    // Request.
    output var  logic      reqValid,
    output var  iag_req_s  req,
    // Register loads.
    output var  logic      regWrEn,
    output var  iag_reg_e  regWrSel,
    output var  logic [2:0] regWrPtr,
    output var  iag_addr_t regWrData
);

    initial begin
        reqValid = 1'b0;
        req = '0;
        regWrEn = 1'b0;
        regWrSel = IAG_REG_IR0;
        regWrPtr = 3'h0;
        regWrData = '0;
    end

    // Released fields show the inverse of the last value so stale data never looks valid.
    task automatic issue(input iag_req_s r);
        @(posedge ref_clk);
        reqValid <= 1'b1;
        req <= r;
        @(posedge ref_clk);
        reqValid <= 1'b0;
        req <= ~r;
    endtask

    task automatic load(input iag_reg_e sel, input logic [2:0] ptr, input iag_addr_t data);
        @(posedge ref_clk);
        regWrEn <= 1'b1;
        regWrSel <= sel;
        regWrPtr <= ptr;
        regWrData <= data;
        @(posedge ref_clk);
        regWrEn <= 1'b0;
        regWrData <= ~data;
    endtask

endmodule

`default_nettype wire

// file: tb/tb_indirect_address_generator.sv
/*
 Self-checking bench for the indirect address generator with a reference model of its registers.
 Assumes the decoder model drives all requests and loads.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_indirect_address_generator;
    import iag_pkg::*;

    localparam int PERIOD = 25;

    logic      ref_clk;
    logic      rst_n;
    logic      reqValid;
    iag_req_s  req;
    logic      regWrEn;
    iag_reg_e  regWrSel;
    logic [2:0] regWrPtr;
    iag_addr_t regWrData;
    logic      resValid;
    iag_res_s  res;
    iag_addr_t stackTopPointer;
    int        miscompares;
    int        tests_run;
    iag_addr_t ar [8];
    iag_addr_t ir0;
    iag_addr_t ir1;
    iag_addr_t bk;
    iag_addr_t sp;

    iag_core dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reqValid(reqValid), .req(req), .regWrEn(regWrEn),
        .regWrSel(regWrSel), .regWrPtr(regWrPtr), .regWrData(regWrData), .resValid(resValid), .res(res),
        .stackTopPointer(stackTopPointer));

    iag_decoder_model farEnd (.ref_clk(ref_clk), .reqValid(reqValid), .req(req), .regWrEn(regWrEn),
        .regWrSel(regWrSel), .regWrPtr(regWrPtr), .regWrData(regWrData));

    always #(PERIOD / 2.0) ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    function automatic iag_addr_t brev(input iag_addr_t x);
        iag_addr_t y;
        for (int i = 0; i < 24; i++) y[i] = x[23-i];
        return y;
    endfunction

    // Buffer window is the power of two above the block size; steps are kept below it.
    function automatic iag_addr_t circ(input iag_addr_t p, input iag_addr_t s, input logic sub);
        iag_addr_t size;
        iag_addr_t base;
        iag_addr_t idx;
        size = 24'h000001;
        while (size <= bk) size = size << 1;
        base = p & ~(size - 24'h000001);
        idx = p - base;
        if (bk == 24'h000000) return sub ? p - s : p + s;
        if (sub) idx = (idx < s) ? idx + bk - s : idx - s;
        else idx = (idx + s >= bk) ? idx + s - bk : idx + s;
        return base + idx;
    endfunction

    task automatic setreg(input iag_reg_e sel, input logic [2:0] ptr, input iag_addr_t d);
        farEnd.load(sel, ptr, d);
    endtask

    task automatic run(input iag_op_e op, input logic [4:0] mode, input logic [2:0] ptr, input logic [7:0] disp,
                       input logic cond, input logic treg, input iag_addr_t target);
        iag_req_s  r;
        iag_addr_t p;
        iag_addr_t step;
        iag_addr_t sum;
        iag_addr_t ea;
        iag_addr_t np;
        iag_addr_t pcn;
        logic      br;
        r = '0;
        r.op = op;
        r.mode = mode;
        r.ptrSel = ptr;
        r.disp = disp;
        r.condTrue = cond;
        r.targetIsReg = treg;
        r.target = target;
        r.pc = iag_addr_t'($urandom);
        r.srcData = $urandom;
        p = ar[ptr];
        step = (mode[4:3] == 2'h0) ? {16'h0000, disp} : (mode[4:3] == 2'h1) ? ir0 : ir1;
        sum = mode[0] ? p - step : p + step;
        ea = p;
        np = p;
        if (mode < 5'h18) begin
            if (!mode[2]) ea = sum;
            if (mode[2:1] != 2'h0) np = (mode[2:1] == 2'h3) ? circ(p, step, mode[0]) : sum;
        end else if (mode == 5'h19) begin
            np = brev(brev(p) + brev(ir0));
        end
        if (op == IAG_OP_DECBR) np = p - 24'h000001;
        br = (op == IAG_OP_DECBR) && cond && !np[23];
        pcn = !br ? r.pc + 24'h000001 : treg ? target : target + r.pc + 24'h000001;
        // The result stands only in the cycle after the taking edge, at which issue returns.
        farEnd.issue(r);
        #1;
        check(resValid, 1'b1);
        check({res.branch, res.pcNext}, {br, pcn});
        if (op == IAG_OP_PUSH) begin
            sp = sp + 24'h000001;
            check({res.addr, stackTopPointer}, {sp, sp});
            check({res.memWrite, res.wData}, {1'b1, r.srcData});
        end else if (op == IAG_OP_POP) begin
            check({res.addr, res.memRead}, {sp, 1'b1});
            sp = sp - 24'h000001;
            check(stackTopPointer, sp);
        end else begin
            check(res.ptrNew, np);
            if (op != IAG_OP_DECBR) check(res.addr, ea);
            check({res.memRead, res.memWrite}, {op == IAG_OP_READ, op == IAG_OP_WRITE});
            ar[ptr] = np;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [4:0] m;
        logic [2:0] ptr;
        iag_op_e    ops [3];
        int         seedSink;
        ops = '{IAG_OP_READ, IAG_OP_WRITE, IAG_OP_NOP};
        ref_clk = 1'b0;
        rst_n = 1'b0;
        miscompares = 0;
        tests_run = 0;
        foreach (ar[i]) ar[i] = 24'h000000;
        sp = 24'h000000;
        bk = 24'h000000;
        ir0 = 24'h000000;
        ir1 = 24'h000000;
        seedSink = $urandom(32'h5B2C);
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        check({resValid, stackTopPointer}, 25'h0000000);
        run(IAG_OP_READ, 5'h18, 3'h7, 8'h00, 1'b0, 1'b0, '0);
        bk = 24'h00000D;
        ir0 = iag_addr_t'($urandom % 12 + 1);
        ir1 = iag_addr_t'($urandom % 12 + 1);
        sp = 24'hFFFFFE;
        setreg(IAG_REG_BK, 3'h0, bk);
        setreg(IAG_REG_IR0, 3'h0, ir0);
        setreg(IAG_REG_IR1, 3'h0, ir1);
        setreg(IAG_REG_SP, 3'h0, sp);
        for (int i = 0; i < 8; i++) begin
            ar[i] = iag_addr_t'($urandom);
            setreg(IAG_REG_AUX, 3'(i), ar[i]);
        end
        // Corner cases that every addressing-mode assertion is sure to see, then the random sweep.
        ar[1] = 24'h12340B;
        setreg(IAG_REG_AUX, 3'h1, ar[1]);
        run(IAG_OP_READ, 5'h00, 3'h1, 8'hFF, 1'b0, 1'b0, '0);
        run(IAG_OP_NOP, 5'h05, 3'h1, 8'h03, 1'b0, 1'b0, '0);
        run(IAG_OP_WRITE, 5'h0A, 3'h1, 8'h00, 1'b0, 1'b0, '0);
        run(IAG_OP_READ, 5'h11, 3'h1, 8'h00, 1'b0, 1'b0, '0);
        run(IAG_OP_NOP, 5'h04, 3'h1, 8'h0C, 1'b0, 1'b0, '0);
        run(IAG_OP_READ, 5'h14, 3'h1, 8'h00, 1'b0, 1'b0, '0);
        run(IAG_OP_WRITE, 5'h18, 3'h1, 8'h00, 1'b0, 1'b0, '0);
        ar[1] = 24'h12340B;
        setreg(IAG_REG_AUX, 3'h1, ar[1]);
        run(IAG_OP_WRITE, 5'h0E, 3'h1, 8'h00, 1'b0, 1'b0, '0);
        run(IAG_OP_READ, 5'h0F, 3'h1, 8'h00, 1'b0, 1'b0, '0);
        for (int k = 0; k < 128; k++) begin
            m = 5'(k);
            ptr = 3'($urandom % 8);
            if (m < 5'h18 && m[2:1] == 2'h3) begin
                ar[ptr] = (iag_addr_t'($urandom) & 24'hFFFFF0) + iag_addr_t'($urandom % 13);
                setreg(IAG_REG_AUX, ptr, ar[ptr]);
            end
            run(ops[$urandom % 3], m, ptr, 8'($urandom % 13), 1'b0, 1'b0, '0);
        end
        ar[2] = 24'h000001;
        setreg(IAG_REG_AUX, 3'h2, ar[2]);
        run(IAG_OP_DECBR, 5'h18, 3'h2, 8'h00, 1'b1, 1'b0, 24'hFFFFF0);
        run(IAG_OP_DECBR, 5'h18, 3'h2, 8'h00, 1'b1, 1'b1, 24'h00ABCD);
        for (int i = 0; i < 16; i++) begin
            run(IAG_OP_DECBR, 5'h18, 3'($urandom), 8'h00, 1'($urandom), 1'($urandom), iag_addr_t'($urandom));
        end
        run(IAG_OP_PUSH, 5'h18, 3'h0, 8'h00, 1'b0, 1'b0, '0);
        run(IAG_OP_PUSH, 5'h18, 3'h0, 8'h00, 1'b0, 1'b0, '0);
        run(IAG_OP_POP, 5'h18, 3'h0, 8'h00, 1'b0, 1'b0, '0);
        run(IAG_OP_POP, 5'h18, 3'h0, 8'h00, 1'b0, 1'b0, '0);
        @(posedge ref_clk);
        #1;
        check({resValid, res.addr, res.memRead, res.memWrite}, 27'h0000000);
        report_and_stop();
    end

    initial begin
        #(PERIOD * 20000);
        miscompares++;
        report_and_stop();
    end

endmodule

`default_nettype wire
